//--- hw/cpd_cfg.svh
// Purpose: constants of the command pulse input decoder
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH

// ****************************************
// register offsets (word index)
// ****************************************
`define CPD_REG_CFG       4'h0
`define CPD_REG_CNT       4'h1
`define CPD_REG_STS       4'h2

// ****************************************
// config fields and reset value
// ****************************************
`define CPD_CFG_W         16
`define CPD_CFG_RST       16'h1011
`define CPD_FMT_LSB       0
`define CPD_TRIG_LSB      4
`define CPD_POL_LSB       8
`define CPD_NEG_BASE      4'h5
`define CPD_FMT_LAST      4'h9

// ****************************************
// status bits
// ****************************************
`define CPD_STS_PHERR     0
`define CPD_STS_CLR       1
`define CPD_STS_NZ        2

// ****************************************
// timing
// ****************************************
`define CPD_SYNC_STAGES   2

`endif

//--- hw/cpd_pkg.sv
// Purpose: types of the command pulse input decoder
// Assumes: nothing
// Notes:   constants live in cpd_cfg.svh
package cpd_pkg;

   // ****************************************
   // pulse format, positive logic codes
   // ****************************************
   typedef enum logic [3:0] {
      CPD_FMT_FEED_DIR = 4'h0,
      CPD_FMT_FWD_REV  = 4'h1,
      CPD_FMT_QUAD_X1  = 4'h2,
      CPD_FMT_QUAD_X2  = 4'h3,
      CPD_FMT_QUAD_X4  = 4'h4,
      CPD_FMT_NONE     = 4'hf
   } cpd_fmt_t;

   // ****************************************
   // external clear trigger
   // ****************************************
   typedef enum logic [1:0] {
      CPD_TRIG_HIGH = 2'h0,
      CPD_TRIG_RISE = 2'h1,
      CPD_TRIG_LOW  = 2'h2,
      CPD_TRIG_FALL = 2'h3
   } cpd_trig_t;

   // ****************************************
   // automatic clear policy
   // ****************************************
   typedef enum logic [3:0] {
      CPD_POL_ALARM_SOFF = 4'h0,
      CPD_POL_KEEP       = 4'h1,
      CPD_POL_ALARM      = 4'h2
   } cpd_pol_t;

endpackage : cpd_pkg

//--- hw/cpd_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: synchronous active-low reset
// Notes:   first stage is read by the second stage only
`timescale 1ns/100ps
module cpd_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r    <= q_nxt;
      end
   end

   assign q = q_r;

endmodule : cpd_sync

//--- hw/cpd_decoder.sv
// Purpose: command pulse input decoder with deviation counter
// Assumes: 100 MHz clk_sys, synchronous active-low reset
// Notes:   pins pass two flip-flops before any logic reads them
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "cpd_cfg.svh"
module cpd_decoder #(
   parameter int CNT_W = 32,
   parameter int DW    = 32,
   parameter int AW    = 4
) (
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic          cmd_a_pin,
   input  wire logic          cmd_b_pin,
   input  wire logic          dev_clr_pin,
   input  wire logic          alarm,
   input  wire logic          servo_on,
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [DW-1:0] reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [DW-1:0] reg_rdata,
   output logic [CNT_W-1:0]   dev_count,
   output logic               dev_clear,
   output logic               cmd_up,
   output logic               cmd_dn
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [2:0] pins_s;

   cpd_sync #(
      .W (3)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({dev_clr_pin, cmd_b_pin, cmd_a_pin}),
      .q       (pins_s)
   );

   // ****************************************
   // config register fields
   // ****************************************
   logic [`CPD_CFG_W-1:0] cfg_r;
   logic [`CPD_CFG_W-1:0] cfg_nxt;
   logic [3:0]            fmt_raw;
   logic [1:0]            trig_raw;
   logic [3:0]            pol_raw;
   logic                  neg_logic;
   cpd_pkg::cpd_fmt_t     fmt;

   assign fmt_raw  = cfg_r[`CPD_FMT_LSB +: 4];
   assign trig_raw = cfg_r[`CPD_TRIG_LSB +: 2];
   assign pol_raw  = cfg_r[`CPD_POL_LSB +: 4];

   // fold formats 5-9 onto 0-4 with inverted inputs
   always_comb begin
      neg_logic = 1'b0;
      fmt       = cpd_pkg::CPD_FMT_NONE;
      if (fmt_raw < `CPD_NEG_BASE) begin
         fmt = cpd_pkg::cpd_fmt_t'(fmt_raw);
      end else if (fmt_raw <= `CPD_FMT_LAST) begin
         neg_logic = 1'b1;
         fmt       = cpd_pkg::cpd_fmt_t'(4'(fmt_raw - `CPD_NEG_BASE));
      end
   end

   // ****************************************
   // edge history of the command lines
   // ****************************************
   logic a_now;
   logic b_now;
   logic clr_now;
   logic a_prev_r;
   logic b_prev_r;
   logic clr_prev_r;
   logic hist_ok_r;
   logic a_prev_nxt;
   logic b_prev_nxt;
   logic clr_prev_nxt;
   logic hist_ok_nxt;
   logic a_prev;
   logic b_prev;

   // polarity applied to both samples so a mode change causes no false edge
   assign a_now   = pins_s[0] ^ neg_logic;
   assign b_now   = pins_s[1] ^ neg_logic;
   assign clr_now = pins_s[2];
   assign a_prev  = a_prev_r ^ neg_logic;
   assign b_prev  = b_prev_r ^ neg_logic;

   always_comb begin
      a_prev_nxt   = pins_s[0];
      b_prev_nxt   = pins_s[1];
      clr_prev_nxt = pins_s[2];
      hist_ok_nxt  = 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         a_prev_r   <= 1'b0;
         b_prev_r   <= 1'b0;
         clr_prev_r <= 1'b0;
         hist_ok_r  <= 1'b0;
      end else begin
         a_prev_r   <= a_prev_nxt;
         b_prev_r   <= b_prev_nxt;
         clr_prev_r <= clr_prev_nxt;
         hist_ok_r  <= hist_ok_nxt;
      end
   end

   // ****************************************
   // pulse decode
   // ****************************************
   logic a_rise;
   logic b_rise;
   logic a_fall;
   logic a_chg;
   logic b_chg;
   logic up;
   logic dn;
   logic ph_err;
   logic q4_fwd;
   logic q4_rev;

   assign a_rise = a_now & ~a_prev;
   assign a_fall = ~a_now & a_prev;
   assign b_rise = b_now & ~b_prev;
   assign a_chg  = a_now ^ a_prev;
   assign b_chg  = b_now ^ b_prev;

   // gray sequence 00-10-11-01 means phase a leads: forward
   always_comb begin
      q4_fwd = 1'b0;
      q4_rev = 1'b0;
      case ({a_prev, b_prev, a_now, b_now})
         4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
            q4_fwd = 1'b1;
         end
         4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
            q4_rev = 1'b1;
         end
         default: begin
            q4_fwd = 1'b0;
         end
      endcase
   end

   always_comb begin
      up     = 1'b0;
      dn     = 1'b0;
      ph_err = 1'b0;
      if (hist_ok_r) begin
         case (fmt)
            cpd_pkg::CPD_FMT_FEED_DIR: begin
               up = a_rise & b_now;
               dn = a_rise & ~b_now;
            end
            cpd_pkg::CPD_FMT_FWD_REV: begin
               // coincident pulses cancel
               up = a_rise & ~b_rise;
               dn = b_rise & ~a_rise;
            end
            cpd_pkg::CPD_FMT_QUAD_X1: begin
               up     = a_rise & ~b_chg & ~b_now;
               dn     = a_rise & ~b_chg & b_now;
               ph_err = a_chg & b_chg;
            end
            cpd_pkg::CPD_FMT_QUAD_X2: begin
               up     = ~b_chg & ((a_rise & ~b_now) | (a_fall & b_now));
               dn     = ~b_chg & ((a_rise & b_now) | (a_fall & ~b_now));
               ph_err = a_chg & b_chg;
            end
            cpd_pkg::CPD_FMT_QUAD_X4: begin
               up     = q4_fwd;
               dn     = q4_rev;
               ph_err = a_chg & b_chg;
            end
            default: begin
               up = 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // clear conditions
   // ****************************************
   logic ext_clr;
   logic auto_clr;
   logic clr_any;

   always_comb begin
      case (cpd_pkg::cpd_trig_t'(trig_raw))
         cpd_pkg::CPD_TRIG_HIGH: ext_clr = clr_now;
         cpd_pkg::CPD_TRIG_RISE: ext_clr = clr_now & ~clr_prev_r & hist_ok_r;
         cpd_pkg::CPD_TRIG_LOW:  ext_clr = ~clr_now;
         cpd_pkg::CPD_TRIG_FALL: ext_clr = ~clr_now & clr_prev_r & hist_ok_r;
         default:                ext_clr = 1'b0;
      endcase
   end

   // alarm and servo-off clear for as long as they stand
   always_comb begin
      case (pol_raw)
         cpd_pkg::CPD_POL_ALARM_SOFF: auto_clr = alarm | ~servo_on;
         cpd_pkg::CPD_POL_ALARM:      auto_clr = alarm;
         default:                     auto_clr = 1'b0;
      endcase
   end

   assign clr_any = ext_clr | auto_clr;

   // ****************************************
   // deviation counter
   // ****************************************
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             clr_r;
   logic             clr_nxt;
   logic             up_r;
   logic             up_nxt;
   logic             dn_r;
   logic             dn_nxt;

   // wraps at the width limit; no overflow is detected or flagged
   always_comb begin
      cnt_nxt = cnt_r;
      if (clr_any) begin
         cnt_nxt = '0;
      end else if (up & ~dn) begin
         cnt_nxt = cnt_r + CNT_W'(1);
      end else if (dn & ~up) begin
         cnt_nxt = cnt_r - CNT_W'(1);
      end
      clr_nxt = clr_any;
      up_nxt  = up & ~dn & ~clr_any;
      dn_nxt  = dn & ~up & ~clr_any;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_r <= '0;
         clr_r <= 1'b0;
         up_r  <= 1'b0;
         dn_r  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         clr_r <= clr_nxt;
         up_r  <= up_nxt;
         dn_r  <= dn_nxt;
      end
   end

   assign dev_count = cnt_r;
   assign dev_clear = clr_r;
   assign cmd_up    = up_r;
   assign cmd_dn    = dn_r;

   // ****************************************
   // register port
   // ****************************************
   logic          pherr_r;
   logic          pherr_nxt;
   logic [DW-1:0] rdata_r;
   logic [DW-1:0] rdata_nxt;
   logic          wr_cfg;
   logic          wr_sts;

   assign wr_cfg = reg_wr && (reg_addr == AW'(`CPD_REG_CFG));
   assign wr_sts = reg_wr && (reg_addr == AW'(`CPD_REG_STS));

   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_cfg) begin
         cfg_nxt = reg_wdata[`CPD_CFG_W-1:0];
      end
      // sticky: a new error beats a clear in the same cycle
      pherr_nxt = pherr_r;
      if (wr_sts && reg_wdata[`CPD_STS_PHERR]) begin
         pherr_nxt = 1'b0;
      end
      if (ph_err) begin
         pherr_nxt = 1'b1;
      end
      rdata_nxt = '0;
      if (reg_rd) begin
         case (reg_addr)
            AW'(`CPD_REG_CFG): begin
               rdata_nxt = DW'(cfg_r);
            end
            AW'(`CPD_REG_CNT): begin
               rdata_nxt = DW'(cnt_r);
            end
            AW'(`CPD_REG_STS): begin
               rdata_nxt[`CPD_STS_PHERR] = pherr_r;
               rdata_nxt[`CPD_STS_CLR]   = clr_r;
               rdata_nxt[`CPD_STS_NZ]    = |cnt_r;
            end
            default: begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_r   <= `CPD_CFG_RST;
         pherr_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         cfg_r   <= cfg_nxt;
         pherr_r <= pherr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

endmodule : cpd_decoder

//--- bench/cpd_decoder_checker.sv
// Purpose: port assertions of the pulse decoder
// Assumes: cfg mirrored from register writes
// Notes:   pin clears are judged by the bench
`timescale 1ns/100ps
module cpd_decoder_checker #(
   parameter int CNT_W = 32,
   parameter int DW    = 32,
   parameter int AW    = 4
) (
   input wire logic             clk_sys,
   input wire logic             rst_n,
   input wire logic             alarm,
   input wire logic             servo_on,
   input wire logic [AW-1:0]    reg_addr,
   input wire logic [DW-1:0]    reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [DW-1:0]    reg_rdata,
   input wire logic [CNT_W-1:0] dev_count,
   input wire logic             dev_clear,
   input wire logic             cmd_up,
   input wire logic             cmd_dn
);
   // *****
   // cfg mirror
   // *****
   logic [15:0] cfg_r;
   logic [15:0] cfg_nxt;
   logic [3:0]  pol;
   assign pol = cfg_r[11:8];
   always_comb begin
      cfg_nxt = cfg_r;
      if (reg_wr && reg_addr == '0) begin
         cfg_nxt = reg_wdata[15:0];
      end
   end
   always_ff @(posedge clk_sys) begin
      cfg_r <= rst_n ? cfg_nxt : 16'h1011;
   end
   // *****
   // properties
   // *****
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_clr_zero: assert property (dev_clear |-> dev_count == '0)
      else $error("count not zero on clear");
   a_step_up: assert property (cmd_up |-> dev_count == CNT_W'($past(dev_count) + 1))
      else $error("up step not plus one");
   a_step_dn: assert property (cmd_dn |-> dev_count == CNT_W'($past(dev_count) - 1))
      else $error("down step not minus one");
   a_one_dir: assert property (!(cmd_up && cmd_dn))
      else $error("up and down together");
   a_count_hold: assert property (!cmd_up && !cmd_dn && !dev_clear |-> $stable(dev_count))
      else $error("count moved without step");
   a_alarm_clr: assert property (alarm && (pol == 4'h0 || pol == 4'h2) |=> dev_clear)
      else $error("alarm did not clear");
   a_soff_clr: assert property (!servo_on && pol == 4'h0 |=> dev_clear)
      else $error("servo off did not clear");
   a_rd_idle: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data outside read");
   a_rd_cfg: assert property (reg_rd && reg_addr == '0 |=> reg_rdata == DW'(cfg_r))
      else $error("config readback wrong");
endmodule : cpd_decoder_checker

bind cpd_decoder cpd_decoder_checker #(.CNT_W(CNT_W), .DW(DW), .AW(AW)) i_cpd_decoder_checker (
   .clk_sys(clk_sys), .rst_n(rst_n), .alarm(alarm), .servo_on(servo_on), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .dev_count(dev_count), .dev_clear(dev_clear), .cmd_up(cmd_up), .cmd_dn(cmd_dn));

//--- bench/cpd_host.sv
// Purpose: host pulse train source
// Assumes: one task call at a time
// Notes:   lines rest inactive between moves
`timescale 1ns/100ps
module cpd_host (
   input  wire logic clk_sys,
   output logic      cmd_a_pin,
   output logic      cmd_b_pin
);
   // *****
   // line drive
   // *****
   logic inv = 1'b0;
   logic a   = 1'b0;
   logic b   = 1'b0;
   int   hp  = 2;
   assign cmd_a_pin = a ^ inv;
   assign cmd_b_pin = b ^ inv;
   // hp of at least two; each step holds its levels for hp clock cycles
   task automatic step(input logic na, input logic nb);
      @(posedge clk_sys);
      a <= na;
      b <= nb;
      repeat (hp - 1) @(posedge clk_sys);
   endtask : step
   // fr low: feed plus direction; fr high: separate lines
   task automatic pulses(input logic fr, input logic dir, input int n);
      step(1'b0, dir & ~fr);
      repeat (n) begin
         step(fr ? dir : 1'b1, fr ? ~dir : dir);
         step(1'b0, dir & ~fr);
      end
      step(1'b0, 1'b0);
   endtask : pulses
   // a leads b by a quarter cycle when dir is high
   task automatic quad(input logic dir, input int n);
      repeat (n) begin
         step(dir, ~dir);
         step(1'b1, 1'b1);
         step(~dir, dir);
         step(1'b0, 1'b0);
      end
   endtask : quad
endmodule : cpd_host

//--- bench/cpd_decoder_bench.sv
// Purpose: self-checking bench of the pulse decoder
// Assumes: host model drives the command pins
// Notes:   counts read back over the register port
`timescale 1ns/100ps
module cpd_decoder_bench;
   logic        clk_sys     = 1'b0;
   logic        rst_n       = 1'b0;
   logic        dev_clr_pin = 1'b0;
   logic        alarm       = 1'b0;
   logic        servo_on    = 1'b1;
   logic [3:0]  reg_addr    = 4'h0;
   logic [31:0] reg_wdata   = 32'h0;
   logic        reg_wr      = 1'b0;
   logic        reg_rd      = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] dev_count;
   logic        dev_clear;
   logic        cmd_up;
   logic        cmd_dn;
   logic        cmd_a_pin;
   logic        cmd_b_pin;
   int          n_fail      = 0;
   int          compares    = 0;
   int          n_up        = 0;
   int          n_dn        = 0;
   always #5 clk_sys = ~clk_sys;
   // step pulses counted so cmd_up and cmd_dn are judged too
   always @(posedge clk_sys) begin
      n_up <= n_up + int'(cmd_up);
      n_dn <= n_dn + int'(cmd_dn);
   end
   cpd_host i_cpd_host (.clk_sys(clk_sys), .cmd_a_pin(cmd_a_pin), .cmd_b_pin(cmd_b_pin));
   cpd_decoder i_cpd_decoder (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_a_pin(cmd_a_pin),
      .cmd_b_pin(cmd_b_pin), .dev_clr_pin(dev_clr_pin), .alarm(alarm), .servo_on(servo_on),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .dev_count(dev_count), .dev_clear(dev_clear), .cmd_up(cmd_up),
      .cmd_dn(cmd_dn));
   // *****
   // helpers
   // *****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(reg_rdata, exp);
   endtask : rdchk
   task automatic clr;
      @(posedge clk_sys);
      alarm <= 1'b1;
      @(posedge clk_sys);
      alarm <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : clr
   task automatic pin(input logic v);
      @(posedge clk_sys);
      dev_clr_pin <= v;
   endtask : pin
   // pin to count takes three edges, so settle before reading
   task automatic move(input int p, input logic dir);
      if (p < 2) begin
         i_cpd_host.pulses(p == 1, dir, 2);
      end else begin
         i_cpd_host.quad(dir, 2);
      end
      repeat (6) @(posedge clk_sys);
   endtask : move
   // *****
   // scenarios
   // *****
   task automatic s_regs;
      rdchk(4'h0, 32'h1011);
      wr(4'h1, 32'h5);
      rdchk(4'h1, 32'h0);
      wr(4'h3, 32'h7);
      rdchk(4'h3, 32'h0);
   endtask : s_regs
   task automatic s_fmt;
      int k;
      int u;
      int d;
      for (int f = 0; f < 10; f++) begin
         wr(4'h0, 32'h0210 | 32'(f));
         i_cpd_host.inv <= (f > 4);
         i_cpd_host.hp = 2 + f % 3;
         repeat (6) @(posedge clk_sys);
         clr;
         k = (f % 5 < 3) ? 2 : ((f % 5 == 3) ? 4 : 8);
         u = n_up;
         d = n_dn;
         move(f % 5, 1'b1);
         chk(dev_count, 32'(k));
         chk(32'(n_up - u), 32'(k));
         rdchk(4'h1, 32'(k));
         move(f % 5, 1'b0);
         move(f % 5, 1'b0);
         chk(32'(n_dn - d), 32'(2 * k));
         rdchk(4'h1, -32'(k));
      end
   endtask : s_fmt
   task automatic s_pol;
      i_cpd_host.inv <= 1'b0;
      for (int p = 0; p < 3; p++) begin
         wr(4'h0, 32'h0011);
         clr;
         wr(4'h0, 32'h0011 | (32'(p) << 8));
         move(1, 1'b1);
         clr;
         rdchk(4'h1, (p == 1) ? 32'h2 : 32'h0);
         move(1, 1'b1);
         @(posedge clk_sys);
         servo_on <= 1'b0;
         repeat (2) @(posedge clk_sys);
         servo_on <= 1'b1;
         repeat (3) @(posedge clk_sys);
         rdchk(4'h1, (p == 0) ? 32'h0 : ((p == 1) ? 32'h4 : 32'h2));
      end
   endtask : s_pol
   task automatic s_trig;
      i_cpd_host.hp = 4;
      wr(4'h2, 32'h1);
      rdchk(4'h2, 32'h4);
      for (int t = 0; t < 4; t++) begin
         wr(4'h0, 32'h0201 | (32'(t) << 4));
         pin(t == 2);
         clr;
         move(1, 1'b1);
         rdchk(4'h1, 32'h2);
         pin(t != 2);
         move(1, 1'b1);
         rdchk(4'h1, (t == 1) ? 32'h2 : ((t == 3) ? 32'h4 : 32'h0));
         if (t == 0) rdchk(4'h2, 32'h2);
         pin(t == 2);
         repeat (6) @(posedge clk_sys);
         rdchk(4'h1, (t == 1) ? 32'h2 : 32'h0);
      end
   endtask : s_trig
   // both phases moving at once: no count, sticky error, write one clears
   task automatic s_sts;
      wr(4'h0, 32'h0214);
      clr;
      i_cpd_host.step(1'b1, 1'b1);
      i_cpd_host.step(1'b0, 1'b0);
      repeat (4) @(posedge clk_sys);
      chk(dev_count, 32'h0);
      rdchk(4'h2, 32'h1);
      wr(4'h2, 32'h1);
      rdchk(4'h2, 32'h0);
   endtask : s_sts
   task automatic close_out;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      s_regs;
      s_fmt;
      s_pol;
      s_trig;
      s_sts;
      close_out;
   end
   initial begin
      repeat (50000) @(posedge clk_sys);
      n_fail++;
      close_out;
   end
endmodule : cpd_decoder_bench
